// ### hw/peripheral_irq_enable_bank.v
// Contract
// - capture units 2/1 gated by bits 6/5
// - timers 6,4,2,3 gated by bits 4,3,2,0
// - timer 3 gate event gated by bit 1
// - pwm register: parameter high, period low bit
// - period enable passes period request
// - parameter enable passes parameter request
// - uart one rx bit 7, tx bit 6
// - bits 5..2 gate logic cells 4..1
// - bit 1 waveform gen, bit 0 oscillator
// - comparators 2/1 gated by bits 7/6
// - sync port two collision bit 5, general 4
// - sync port one collision bit 3, general 2
// - uart two rx bit 1, tx bit 0
// - enable registers read/write, reset to zero
// - flags set regardless of any enable
// - peripheral global enable required for vectoring
// - global enable allows or blocks all vectoring
`timescale 1ns/1ps
`default_nettype none
`include "peripheral_irq_enable_bank_regs.vh"

module peripheral_irq_enable_bank #(
  parameter ADDR_WIDTH = 12
) (
  input  wire                  core_clk,
  input  wire                  rst_n,
  // classic wishbone slave
  input  wire                  cyc_i,
  input  wire                  stb_i,
  input  wire                  we_i,
  input  wire [ADDR_WIDTH-1:0] adr_i,
  input  wire [3:0]            sel_i,
  input  wire [31:0]           dat_i,
  output reg  [31:0]           dat_o,
  output reg                   ack_o,
  // request flags raised by the peripherals
  input  wire [6:0]            captureTimerFlags,
  input  wire [7:0]            pwmFlags,
  input  wire [7:0]            serialLogicFlags,
  input  wire [7:0]            comparatorPortFlags,
  // gated requests toward the interrupt core
  output reg  [6:0]            captureTimerReqs,
  output reg  [7:0]            pwmReqs,
  output reg  [7:0]            serialLogicReqs,
  output reg  [7:0]            comparatorPortReqs,
  output reg                   peripheralReq,
  output reg                   vectorReq,
  output reg                   irq
);

  // enable, control, status and mask state
  reg  [6:0]  captureTimerEnReg;
  reg  [7:0]  pwmEnReg;
  reg  [7:0]  serialLogicEnReg;
  reg  [7:0]  comparatorPortEnReg;
  reg         globalIrqEnReg;
  reg         peripheralIrqGlobalEnReg;
  reg  [3:0]  irqStatusReg;
  reg  [3:0]  irqMaskReg;
  reg  [3:0]  groupReqPrevReg;
  reg  [31:0] datNext;
  reg  [3:0]  irqStatusNext;
  reg  [3:0]  irqMaskNext;

  wire [9:0]  regIndex;
  wire        busReq;
  wire        writeStrobe;
  wire        lane0Write;
  wire        captureTimerEnWrite;
  wire        pwmEnWrite;
  wire        serialLogicEnWrite;
  wire        comparatorPortEnWrite;
  wire        controlWrite;
  wire        maskWrite;
  wire        statusWrite;

  // named enables
  wire capcompTwoIrqEn;
  wire capcompOneIrqEn;
  wire timerSixIrqEn;
  wire timerFourIrqEn;
  wire timerTwoIrqEn;
  wire timerThreeGateIrqEn;
  wire timerThreeIrqEn;
  wire pwmFourParamIrqEn;
  wire pwmFourPeriodIrqEn;
  wire pwmThreeParamIrqEn;
  wire pwmThreePeriodIrqEn;
  wire pwmTwoParamIrqEn;
  wire pwmTwoPeriodIrqEn;
  wire pwmOneParamIrqEn;
  wire pwmOnePeriodIrqEn;
  wire uartOneRxIrqEn;
  wire uartOneTxIrqEn;
  wire logicCellFourIrqEn;
  wire logicCellThreeIrqEn;
  wire logicCellTwoIrqEn;
  wire logicCellOneIrqEn;
  wire waveformGenIrqEn;
  wire numOscIrqEn;
  wire comparatorTwoIrqEn;
  wire comparatorOneIrqEn;
  wire syncPortTwoCollisionIrqEn;
  wire syncPortTwoIrqEn;
  wire syncPortOneCollisionIrqEn;
  wire syncPortOneIrqEn;
  wire uartTwoRxIrqEn;
  wire uartTwoTxIrqEn;

  wire [6:0] captureTimerGate;
  wire [7:0] pwmGate;
  wire [7:0] serialLogicGate;
  wire [7:0] comparatorPortGate;
  wire [3:0] groupReq;
  wire       anyReq;
  wire [3:0] groupRise;

  // bus decode: one aligned word per register
  assign regIndex    = adr_i[11:2];
  assign busReq      = cyc_i & stb_i;
  // write lands on the edge where the master sees ack
  assign writeStrobe = busReq & we_i & ack_o;
  assign lane0Write  = writeStrobe & sel_i[0];
  // one strobe per writable word keeps each register in its own process
  assign captureTimerEnWrite   =
    lane0Write & (regIndex == `IDX_CAPTURE_TIMER_EN);
  assign pwmEnWrite            =
    lane0Write & (regIndex == `IDX_PWM_EN);
  assign serialLogicEnWrite    =
    lane0Write & (regIndex == `IDX_SERIAL_LOGIC_EN);
  assign comparatorPortEnWrite =
    lane0Write & (regIndex == `IDX_COMPARATOR_PORT_EN);
  assign controlWrite          =
    lane0Write & (regIndex == `IDX_IRQ_CONTROL);
  assign maskWrite             =
    lane0Write & (regIndex == `IDX_IRQ_MASK);
  assign statusWrite           =
    lane0Write & (regIndex == `IDX_IRQ_STATUS);

  assign capcompTwoIrqEn     = captureTimerEnReg[`CAPCOMP_TWO_BIT];
  assign capcompOneIrqEn     = captureTimerEnReg[`CAPCOMP_ONE_BIT];
  assign timerSixIrqEn       = captureTimerEnReg[`TIMER_SIX_BIT];
  assign timerFourIrqEn      = captureTimerEnReg[`TIMER_FOUR_BIT];
  assign timerTwoIrqEn       = captureTimerEnReg[`TIMER_TWO_BIT];
  assign timerThreeIrqEn     = captureTimerEnReg[`TIMER_THREE_BIT];
  assign timerThreeGateIrqEn = captureTimerEnReg[`TIMER_THREE_GATE_BIT];

  assign pwmFourParamIrqEn   = pwmEnReg[`PWM_FOUR_PARAM_BIT];
  assign pwmThreeParamIrqEn  = pwmEnReg[`PWM_THREE_PARAM_BIT];
  assign pwmTwoParamIrqEn    = pwmEnReg[`PWM_TWO_PARAM_BIT];
  assign pwmOneParamIrqEn    = pwmEnReg[`PWM_ONE_PARAM_BIT];
  assign pwmFourPeriodIrqEn  = pwmEnReg[`PWM_FOUR_PERIOD_BIT];
  assign pwmThreePeriodIrqEn = pwmEnReg[`PWM_THREE_PERIOD_BIT];
  assign pwmTwoPeriodIrqEn   = pwmEnReg[`PWM_TWO_PERIOD_BIT];
  assign pwmOnePeriodIrqEn   = pwmEnReg[`PWM_ONE_PERIOD_BIT];

  assign uartOneRxIrqEn      = serialLogicEnReg[`UART_ONE_RX_BIT];
  assign uartOneTxIrqEn      = serialLogicEnReg[`UART_ONE_TX_BIT];
  assign logicCellFourIrqEn  = serialLogicEnReg[`LOGIC_CELL_FOUR_BIT];
  assign logicCellThreeIrqEn = serialLogicEnReg[`LOGIC_CELL_THREE_BIT];
  assign logicCellTwoIrqEn   = serialLogicEnReg[`LOGIC_CELL_TWO_BIT];
  assign logicCellOneIrqEn   = serialLogicEnReg[`LOGIC_CELL_ONE_BIT];
  assign waveformGenIrqEn    = serialLogicEnReg[`WAVEFORM_GEN_BIT];
  assign numOscIrqEn         = serialLogicEnReg[`NUM_OSC_BIT];

  assign comparatorTwoIrqEn  = comparatorPortEnReg[`COMPARATOR_TWO_BIT];
  assign comparatorOneIrqEn  = comparatorPortEnReg[`COMPARATOR_ONE_BIT];
  assign syncPortTwoCollisionIrqEn =
    comparatorPortEnReg[`SYNC_TWO_COLLISION_BIT];
  assign syncPortTwoIrqEn    = comparatorPortEnReg[`SYNC_TWO_BIT];
  assign syncPortOneCollisionIrqEn =
    comparatorPortEnReg[`SYNC_ONE_COLLISION_BIT];
  assign syncPortOneIrqEn    = comparatorPortEnReg[`SYNC_ONE_BIT];
  assign uartTwoRxIrqEn      = comparatorPortEnReg[`UART_TWO_RX_BIT];
  assign uartTwoTxIrqEn      = comparatorPortEnReg[`UART_TWO_TX_BIT];

  assign captureTimerGate = captureTimerFlags & {
    capcompTwoIrqEn, capcompOneIrqEn, timerSixIrqEn, timerFourIrqEn,
    timerTwoIrqEn, timerThreeGateIrqEn, timerThreeIrqEn};
  assign pwmGate = pwmFlags & {
    pwmFourParamIrqEn, pwmFourPeriodIrqEn,
    pwmThreeParamIrqEn, pwmThreePeriodIrqEn,
    pwmTwoParamIrqEn, pwmTwoPeriodIrqEn,
    pwmOneParamIrqEn, pwmOnePeriodIrqEn};
  assign serialLogicGate = serialLogicFlags & {
    uartOneRxIrqEn, uartOneTxIrqEn, logicCellFourIrqEn,
    logicCellThreeIrqEn, logicCellTwoIrqEn, logicCellOneIrqEn,
    waveformGenIrqEn, numOscIrqEn};
  assign comparatorPortGate = comparatorPortFlags & {
    comparatorTwoIrqEn, comparatorOneIrqEn,
    syncPortTwoCollisionIrqEn, syncPortTwoIrqEn,
    syncPortOneCollisionIrqEn, syncPortOneIrqEn,
    uartTwoRxIrqEn, uartTwoTxIrqEn};

  // one request per register, then one overall
  assign groupReq[`STS_CAPTURE_TIMER_BIT]   = |captureTimerGate;
  assign groupReq[`STS_PWM_BIT]             = |pwmGate;
  assign groupReq[`STS_SERIAL_LOGIC_BIT]    = |serialLogicGate;
  assign groupReq[`STS_COMPARATOR_PORT_BIT] = |comparatorPortGate;
  assign anyReq    = |groupReq;
  // a group going from no gated request to any is the status event
  assign groupRise = groupReq & ~groupReqPrevReg;

  // read mux, unmapped words read as zero
  always @* begin
    datNext = 32'h0000_0000;
    case (regIndex)
      `IDX_IRQ_CONTROL: begin
        datNext[`CTL_GLOBAL_BIT] = globalIrqEnReg;
        datNext[`CTL_PERIPH_BIT] = peripheralIrqGlobalEnReg;
      end
      `IDX_CAPTURE_TIMER_FLAGS:   datNext[6:0] = captureTimerFlags;
      `IDX_PWM_FLAGS:             datNext[7:0] = pwmFlags;
      `IDX_SERIAL_LOGIC_FLAGS:    datNext[7:0] = serialLogicFlags;
      `IDX_COMPARATOR_PORT_FLAGS: datNext[7:0] = comparatorPortFlags;
      `IDX_CAPTURE_TIMER_EN:      datNext[6:0] = captureTimerEnReg;
      `IDX_PWM_EN:                datNext[7:0] = pwmEnReg;
      `IDX_SERIAL_LOGIC_EN:       datNext[7:0] = serialLogicEnReg;
      `IDX_COMPARATOR_PORT_EN:    datNext[7:0] = comparatorPortEnReg;
      `IDX_IRQ_STATUS:            datNext[3:0] = irqStatusReg;
      `IDX_IRQ_MASK:              datNext[3:0] = irqMaskReg;
      default:                    datNext = 32'h0000_0000;
    endcase
  end

  // bus handshake: ack one cycle after the request, dropped after
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= busReq & ~ack_o;
      dat_o <= (busReq & ~we_i & ~ack_o) ? datNext : 32'h0000_0000;
    end
  end

  // software writable enables, cleared by reset
  // capture/timer word, bit 7 not implemented
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      captureTimerEnReg <= `RST_CAPTURE_TIMER_EN;
    end else if (captureTimerEnWrite) begin
      captureTimerEnReg <= dat_i[6:0];
    end
  end

  // pwm word, parameter and period pairs
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwmEnReg <= `RST_ENABLES;
    end else if (pwmEnWrite) begin
      pwmEnReg <= dat_i[7:0];
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      serialLogicEnReg <= `RST_ENABLES;
    end else if (serialLogicEnWrite) begin
      serialLogicEnReg <= dat_i[7:0];
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      comparatorPortEnReg <= `RST_ENABLES;
    end else if (comparatorPortEnWrite) begin
      comparatorPortEnReg <= dat_i[7:0];
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      globalIrqEnReg           <= 1'b0;
      peripheralIrqGlobalEnReg <= 1'b0;
    end else if (controlWrite) begin
      globalIrqEnReg           <= dat_i[`CTL_GLOBAL_BIT];
      peripheralIrqGlobalEnReg <= dat_i[`CTL_PERIPH_BIT];
    end
  end

  // mask as it stands after this edge, so irq sees a new mask at once
  always @* begin
    irqMaskNext = irqMaskReg;
    if (maskWrite) begin
      irqMaskNext = dat_i[3:0];
    end
  end

  // event mask register
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqMaskReg <= `RST_MASK;
    end else begin
      irqMaskReg <= irqMaskNext;
    end
  end

  // sticky status, write one to clear; a fresh event beats the clear
  always @* begin
    irqStatusNext = irqStatusReg;
    if (statusWrite) begin
      irqStatusNext = irqStatusReg & ~dat_i[3:0];
    end
    irqStatusNext = irqStatusNext | groupRise;
  end

  // status register
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqStatusReg <= `RST_STATUS;
    end else begin
      irqStatusReg <= irqStatusNext;
    end
  end

  // last cycle's group requests, for the rising-edge event
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      groupReqPrevReg <= 4'h0;
    end else begin
      groupReqPrevReg <= groupReq;
    end
  end

  // registered outputs toward the interrupt core
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      captureTimerReqs   <= 7'h00;
      pwmReqs            <= 8'h00;
      serialLogicReqs    <= 8'h00;
      comparatorPortReqs <= 8'h00;
      peripheralReq      <= 1'b0;
      vectorReq          <= 1'b0;
      irq                <= 1'b0;
    end else begin
      captureTimerReqs   <= captureTimerGate;
      pwmReqs            <= pwmGate;
      serialLogicReqs    <= serialLogicGate;
      comparatorPortReqs <= comparatorPortGate;
      peripheralReq      <= anyReq;
      vectorReq <= anyReq & peripheralIrqGlobalEnReg & globalIrqEnReg;
      // level output: status under mask, as both stand after the edge
      irq       <= |(irqStatusNext & irqMaskNext);
    end
  end

endmodule // peripheral_irq_enable_bank
`default_nettype wire

// ### hw/peripheral_irq_enable_bank_regs.vh
`ifndef PERIPHERAL_IRQ_ENABLE_BANK_REGS_VH
`define PERIPHERAL_IRQ_ENABLE_BANK_REGS_VH

// register indices, byte address is four times the index
`define IDX_IRQ_CONTROL           10'h00B
`define IDX_CAPTURE_TIMER_FLAGS   10'h08E
`define IDX_PWM_FLAGS             10'h08F
`define IDX_SERIAL_LOGIC_FLAGS    10'h090
`define IDX_COMPARATOR_PORT_FLAGS 10'h091
`define IDX_CAPTURE_TIMER_EN      10'h098
`define IDX_PWM_EN                10'h099
`define IDX_SERIAL_LOGIC_EN       10'h09A
`define IDX_COMPARATOR_PORT_EN    10'h09B
`define IDX_IRQ_STATUS            10'h0A0
`define IDX_IRQ_MASK              10'h0A1

// reset values
`define RST_ENABLES               8'h00
`define RST_CAPTURE_TIMER_EN      7'h00
`define RST_CONTROL               8'h00
`define RST_STATUS                4'h0
`define RST_MASK                  4'h0

// control register fields
`define CTL_GLOBAL_BIT            7
`define CTL_PERIPH_BIT            6

// capture/timer enable fields
`define CAPCOMP_TWO_BIT           6
`define CAPCOMP_ONE_BIT           5
`define TIMER_SIX_BIT             4
`define TIMER_FOUR_BIT            3
`define TIMER_TWO_BIT             2
`define TIMER_THREE_GATE_BIT      1
`define TIMER_THREE_BIT           0

// pwm enable fields: odd bit parameter, even bit period
`define PWM_FOUR_PARAM_BIT        7
`define PWM_FOUR_PERIOD_BIT       6
`define PWM_THREE_PARAM_BIT       5
`define PWM_THREE_PERIOD_BIT      4
`define PWM_TWO_PARAM_BIT         3
`define PWM_TWO_PERIOD_BIT        2
`define PWM_ONE_PARAM_BIT         1
`define PWM_ONE_PERIOD_BIT        0

// serial/logic enable fields
`define UART_ONE_RX_BIT           7
`define UART_ONE_TX_BIT           6
`define LOGIC_CELL_FOUR_BIT       5
`define LOGIC_CELL_THREE_BIT      4
`define LOGIC_CELL_TWO_BIT        3
`define LOGIC_CELL_ONE_BIT        2
`define WAVEFORM_GEN_BIT          1
`define NUM_OSC_BIT               0

// comparator/port enable fields
`define COMPARATOR_TWO_BIT        7
`define COMPARATOR_ONE_BIT        6
`define SYNC_TWO_COLLISION_BIT    5
`define SYNC_TWO_BIT              4
`define SYNC_ONE_COLLISION_BIT    3
`define SYNC_ONE_BIT              2
`define UART_TWO_RX_BIT           1
`define UART_TWO_TX_BIT           0

// status and mask fields, one per enable register
`define STS_CAPTURE_TIMER_BIT     0
`define STS_PWM_BIT               1
`define STS_SERIAL_LOGIC_BIT      2
`define STS_COMPARATOR_PORT_BIT   3

`endif

// ### test/peripheral_irq_enable_bank_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module peripheral_irq_enable_bank_assertions #(
  parameter ADDR_WIDTH = 12
) (
  input wire logic                  core_clk,
  input wire logic                  rst_n,
  input wire logic                  cyc_i,
  input wire logic                  stb_i,
  input wire logic                  we_i,
  input wire logic [ADDR_WIDTH-1:0] adr_i,
  input wire logic [3:0]            sel_i,
  input wire logic [31:0]           dat_i,
  input wire logic [31:0]           dat_o,
  input wire logic                  ack_o,
  input wire logic [6:0]            captureTimerFlags,
  input wire logic [7:0]            pwmFlags,
  input wire logic [7:0]            serialLogicFlags,
  input wire logic [7:0]            comparatorPortFlags,
  input wire logic [6:0]            captureTimerReqs,
  input wire logic [7:0]            pwmReqs,
  input wire logic [7:0]            serialLogicReqs,
  input wire logic [7:0]            comparatorPortReqs,
  input wire logic                  peripheralReq,
  input wire logic                  vectorReq,
  input wire logic                  irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // one answer per request, exactly one cycle later
  property p_ack; cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o; endproperty
  // a gated request needs its flag one edge before
  property p_cap; (captureTimerReqs & ~$past(captureTimerFlags)) == 7'h00;
  endproperty
  property p_pwm; (pwmReqs & ~$past(pwmFlags)) == 8'h00; endproperty
  property p_ser; (serialLogicReqs & ~$past(serialLogicFlags)) == 8'h00;
  endproperty
  property p_cmp; (comparatorPortReqs & ~$past(comparatorPortFlags)) == 8'h00;
  endproperty
  property p_or; peripheralReq == |{captureTimerReqs, pwmReqs,
    serialLogicReqs, comparatorPortReqs}; endproperty
  property p_vec; vectorReq |-> peripheralReq; endproperty
  // read data only in the ack cycle, upper bytes always zero
  property p_rdz; !ack_o |-> dat_o == 32'h0; endproperty
  property p_rdh; ack_o |-> dat_o[31:8] == 24'h0; endproperty
  a_ack: assert property (p_ack) else $error("ack timing wrong");
  a_cap: assert property (p_cap)
    else $error("capture req w/o flag");
  a_pwm: assert property (p_pwm) else $error("pwm req w/o flag");
  a_ser: assert property (p_ser)
    else $error("serial req w/o flag");
  a_cmp: assert property (p_cmp)
    else $error("port req w/o flag");
  a_or: assert property (p_or) else $error("peripheral or wrong");
  a_vec: assert property (p_vec) else $error("vector w/o request");
  a_rdz: assert property (p_rdz) else $error("data outside ack");
  a_rdh: assert property (p_rdh) else $error("upper data bits set");
  c_vec: cover property ($rose(vectorReq));
  c_irq: cover property ($rose(irq));
  c_rd: cover property (ack_o && !we_i);
endmodule // peripheral_irq_enable_bank_assertions
bind peripheral_irq_enable_bank peripheral_irq_enable_bank_assertions #(
  .ADDR_WIDTH(ADDR_WIDTH)) chk_u (.core_clk(core_clk), .rst_n(rst_n),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
  .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .captureTimerFlags(captureTimerFlags), .pwmFlags(pwmFlags),
  .serialLogicFlags(serialLogicFlags),
  .comparatorPortFlags(comparatorPortFlags),
  .captureTimerReqs(captureTimerReqs), .pwmReqs(pwmReqs),
  .serialLogicReqs(serialLogicReqs), .comparatorPortReqs(comparatorPortReqs),
  .peripheralReq(peripheralReq), .vectorReq(vectorReq), .irq(irq));
`default_nettype wire

// ### test/peripheral_flag_model.sv
`timescale 1ns/1ps
`default_nettype none
module peripheral_flag_model (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        raise,
  input  wire logic [30:0] events,
  output var  logic [6:0]  captureTimerFlags,
  output var  logic [7:0]  pwmFlags,
  output var  logic [7:0]  serialLogicFlags,
  output var  logic [7:0]  comparatorPortFlags
);
  // flags ignore enables
  // flags move only when told, so a slow peripheral is just a late raise
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      {comparatorPortFlags, serialLogicFlags, pwmFlags,
       captureTimerFlags} <= 31'h0;
    else if (raise)
      {comparatorPortFlags, serialLogicFlags, pwmFlags,
       captureTimerFlags} <= events;
  end
endmodule // peripheral_flag_model
`default_nettype wire

// ### test/test_peripheral_irq_enable_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "peripheral_irq_enable_bank_regs.vh"
module test_peripheral_irq_enable_bank;
  logic        core_clk, rst_n, cyc_i, stb_i, we_i, ack_o, raise;
  logic        peripheralReq, vectorReq, irq;
  logic [11:0] adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o, expQ[$];
  logic [30:0] events, reqs;
  logic [6:0]  ctFlags, ctReqs;
  logic [7:0]  pwFlags, slFlags, cpFlags, pwReqs, slReqs, cpReqs, v;
  int          miscompares, n_tests, g, b, off;
  assign reqs = {cpReqs, slReqs, pwReqs, ctReqs};
  peripheral_irq_enable_bank dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .captureTimerFlags(ctFlags),
    .pwmFlags(pwFlags), .serialLogicFlags(slFlags),
    .comparatorPortFlags(cpFlags), .captureTimerReqs(ctReqs),
    .pwmReqs(pwReqs), .serialLogicReqs(slReqs),
    .comparatorPortReqs(cpReqs), .peripheralReq(peripheralReq),
    .vectorReq(vectorReq), .irq(irq));
  peripheral_flag_model model_u (
    .core_clk(core_clk), .rst_n(rst_n), .raise(raise), .events(events),
    .captureTimerFlags(ctFlags), .pwmFlags(pwFlags),
    .serialLogicFlags(slFlags), .comparatorPortFlags(cpFlags));
  function automatic logic [9:0] en(input int k);
    return 10'(`IDX_CAPTURE_TIMER_EN + k);
  endfunction
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic conclude;
    // a note left in the queue is a read that never answered
    if (expQ.size() != 0)
      miscompares++;
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [9:0] idx,
                    input logic [7:0] d, input logic [3:0] s);
    int i;
    @(posedge core_clk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= {idx, 2'b00};
    sel_i <= s;
    dat_i <= ($urandom & 32'hFFFFFF00) | {24'h0, d};
    for (i = 0; i < 20 && ack_o !== 1'b1; i++)
      @(posedge core_clk);
    if (ack_o !== 1'b1) begin
      miscompares++;
      conclude;
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d,
                    input logic [3:0] s);
    wb(1'b1, idx, d, s);
  endtask
  task automatic rd(input logic [9:0] idx, input logic [7:0] e);
    expQ.push_back({24'h0, e});
    wb(1'b0, idx, 8'h00, 4'hF);
  endtask
  // peripherals raise flags, then let the registered outputs settle
  task automatic settle(input logic [30:0] ev);
    @(posedge core_clk);
    events <= ev;
    raise  <= 1'b1;
    @(posedge core_clk);
    raise  <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
  endtask
  // read scoreboard: oldest note against each read answer
  always @(posedge core_clk) begin
    if (ack_o === 1'b1 && we_i === 1'b0 && expQ.size() > 0)
      check(dat_o, expQ.pop_front());
  end
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    {rst_n, cyc_i, stb_i, we_i, raise} = 5'h00;
    {adr_i, sel_i, dat_i, events} = '0;
    miscompares = 0;
    n_tests = 0;
    v = 8'($urandom(32'h5C01E423));
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    for (g = 0; g < 4; g++)
      rd(en(g), 8'h00);
    rd(`IDX_IRQ_CONTROL, 8'h00);
    rd(`IDX_IRQ_STATUS, 8'h00);
    $display("reset values done");
    // random read/write, ignored low-sel write and hole
    for (g = 0; g < 4; g++) begin
      v = 8'($urandom);
      wr(en(g), v, 4'h1);
      wr(en(g), ~v, 4'hE);
      rd(en(g), (g == 0) ? (v & 8'h7F) : v);
      wr(en(g), 8'h00, 4'h1);
    end
    wr(10'h3FF, 8'hFF, 4'hF);
    rd(10'h3FF, 8'h00);
    $display("read write done");
    // each enable bit passes exactly its own source
    for (g = 0; g < 4; g++) begin
      off = (g == 0) ? 0 : g * 8 - 1;
      for (b = 0; b < ((g == 0) ? 7 : 8); b++) begin
        wr(en(g), 8'(1 << b), 4'hF);
        settle(31'h7FFFFFFF);
        check(32'(reqs), 32'h1 << (b + off));
        check(32'(peripheralReq), 32'h1);
        check(32'(vectorReq), 32'h0);
        wr(en(g), ~8'(1 << b), 4'hF);
        settle(31'h1 << (b + off));
        check(32'(reqs), 32'h0);
      end
      wr(en(g), 8'h00, 4'hF);
    end
    $display("gating done");
    wr(en(0), 8'h7F, 4'hF);
    for (g = 0; g < 4; g++) begin
      wr(`IDX_IRQ_CONTROL, 8'(g << 6), 4'hF);
      settle(31'h7FFFFFFF);
      check(32'(vectorReq), 32'(g == 3));
    end
    $display("global enables done");
    // flag readable while disabled, then status and irq
    wr(en(0), 8'h00, 4'hF);
    settle(31'h0);
    wr(`IDX_IRQ_STATUS, 8'h0F, 4'hF);
    wr(`IDX_IRQ_MASK, 8'h00, 4'hF);
    settle(31'h1 << 15);
    rd(`IDX_SERIAL_LOGIC_FLAGS, 8'h01);
    rd(`IDX_IRQ_STATUS, 8'h00);
    wr(en(2), 8'h01, 4'hF);
    settle(31'h1 << 15);
    rd(`IDX_IRQ_STATUS, 8'h04);
    check(32'(irq), 32'h0);
    wr(`IDX_IRQ_MASK, 8'h04, 4'hF);
    settle(31'h1 << 15);
    check(32'(irq), 32'h1);
    wr(`IDX_IRQ_STATUS, 8'h04, 4'hF);
    settle(31'h1 << 15);
    check(32'(irq), 32'h0);
    rd(`IDX_IRQ_STATUS, 8'h00);
    $display("interrupt done");
    // a reset in mid-run clears written enables and the mask
    wr(en(1), 8'hA5, 4'hF);
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(en(1), 8'h00);
    rd(`IDX_IRQ_MASK, 8'h00);
    // let the scoreboard take the last answer before the verdict
    repeat (2) @(posedge core_clk);
    #1;
    check(32'(irq), 32'h0);
    check(32'(vectorReq), 32'h0);
    $display("mid-run reset done");
    conclude;
  end
endmodule // test_peripheral_irq_enable_bank
`default_nettype wire
